// [src/sms_consts.svh]
// constants of the switch carrier register bank: offsets, fields, reset values
// assumes byte addresses from the bus host; A16 space is 64 bytes,
// extended space is eight module windows
`ifndef SMS_CONSTS_SVH
`define SMS_CONSTS_SVH

// ----------------------------------------
// A16 space
// ----------------------------------------
`define SMS_A16_AW 6
`define SMS_STROBE_OFF 6'h3e

// ----------------------------------------
// extended space windows
// ----------------------------------------
`define SMS_EXT_AW 13
`define SMS_WIN_LSB 10
`define SMS_WIN_MSB 12
`define SMS_NUM_MOD 3'h6
`define SMS_IMPL_MOD 3'h0
`define SMS_CTRL_OFF 10'h200
`define SMS_RELAY_HI_MSB 9
`define SMS_RELAY_HI_LSB 5
`define SMS_RELAY_HI_ZERO 5'h00

// ----------------------------------------
// fields and fixed values
// ----------------------------------------
`define SMS_DW 16
`define SMS_ONES 16'hffff
`define SMS_STAT_PAD 9'h1ff
`define SMS_STAT_PAD_LSB 7
`define SMS_STAT_WIDE 6
`define SMS_CTRL_HI 10
`define SMS_CTRL_LO 8
`define SMS_CTRL_LATCH 2
`define SMS_CTRL_POL 1
`define SMS_CTRL_PF 0
`define SMS_CTRL_RST 3'h0
`define SMS_RELAY_AW 4
`define SMS_RELAY_WORDS 16

`endif

// [src/sms_pkg.sv]
// types shared by the switch carrier register bank
// assumes sms_consts.svh supplies the widths
`include "sms_consts.svh"

package sms_pkg;
    typedef logic [`SMS_DW-1:0] sms_word_t;
    // which register a bus access lands on
    typedef enum logic [1:0] {
        tgt_strobe,
        tgt_ctrl,
        tgt_relay,
        tgt_rsvd
    } sms_tgt_t;
endpackage

// [src/sms_relay_store.sv]
// relay data words of the one implemented plug-in module
// assumes a single clock; clear wipes every word in one cycle
`timescale 1ns/10ps
`include "sms_consts.svh"

module sms_relay_store
    import sms_pkg::*;
(
    // clock
    input wire logic i_core_clk,
    // control
    input wire logic i_clear,
    input wire logic i_we,
    input wire logic [`SMS_RELAY_AW-1:0] i_addr,
    input wire sms_word_t i_wdata,
    // read data, registered
    output sms_word_t o_rdata
);
    sms_word_t mem_q [`SMS_RELAY_WORDS];

    always_ff @(posedge i_core_clk) begin
        if (i_clear) begin
            for (int i = 0; i < `SMS_RELAY_WORDS; i++) begin
                mem_q[i] <= '0;
            end
        end else if (i_we) begin
            mem_q[i_addr] <= i_wdata;
        end
    end

    // read of the old word when a write hits the same address
    always_ff @(posedge i_core_clk) begin
        o_rdata <= mem_q[i_addr];
    end
endmodule

// [src/sms_regs.sv]
// register bank of the relay switch carrier: strobe, status, control, relay data
// assumes bus requests are one-cycle pulses per completed host cycle,
// synchronous to i_core_clk
`timescale 1ns/10ps
`include "sms_consts.svh"

// Overview of operation
// - any write to the strobe offset raises a trace advance; data ignored
// - status read returns ones in bits 15 to 7
// - status bit 6 reports carrier width, one for double wide
// - status bits 5..0 read one while module n relays still move
// - reserved locations ignore writes and read all ones
// - each module owns a 1024 byte window in extended space
// - upper 512 bytes hold configuration; control register at base plus 0x200
// - six positions reserved, only module 0 implemented, rest unused
// - latch bit selects single coil reset or multi coil; resets zero
// - latch bit acts only on latching relay variants
// - polarity bit inverts relay data read back; resets zero
// - control and status reads are never inverted
// - power fail resets relays unless gate bit set; resets zero
module sms_regs
    import sms_pkg::*;
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_srst,
    // host register access
    input wire logic i_bus_req,
    input wire logic i_bus_wr,
    input wire logic i_bus_ext,
    input wire logic [`SMS_EXT_AW-1:0] i_bus_addr,
    input wire sms_word_t i_bus_wdata,
    output logic o_bus_ack,
    output sms_word_t o_bus_rdata,
    // carrier and module status
    input wire logic i_double_wide,
    input wire logic [5:0] i_module_busy,
    input wire logic i_latching_variant,
    input wire logic i_bus_power_fail_line_n,
    // module control outputs
    output logic o_trace_advance,
    output logic o_latch_multi_coil,
    output logic o_relay_reset
);
    // ----------------------------------------
    // address decode
    // ----------------------------------------
    function automatic logic [2:0] module_base_address(input logic [`SMS_EXT_AW-1:0] a);
        return a[`SMS_WIN_MSB:`SMS_WIN_LSB];
    endfunction

    wire [2:0] mod_idx;
    wire [`SMS_WIN_LSB-1:0] mod_off;
    wire strobe_hit;
    wire mod0_hit;
    wire ctrl_hit;
    wire relay_hit;
    wire wr_take;
    wire rd_take;
    sms_tgt_t tgt;

    assign mod_idx = module_base_address(i_bus_addr);
    assign mod_off = i_bus_addr[`SMS_WIN_LSB-1:0];
    assign strobe_hit = !i_bus_ext && (i_bus_addr[`SMS_A16_AW-1:0] == `SMS_STROBE_OFF);
    // positions 1..5 fall through to reserved
    assign mod0_hit = i_bus_ext && (mod_idx == `SMS_IMPL_MOD);
    assign ctrl_hit = mod0_hit && (mod_off == `SMS_CTRL_OFF);
    assign relay_hit = mod0_hit
        && (mod_off[`SMS_RELAY_HI_MSB:`SMS_RELAY_HI_LSB] == `SMS_RELAY_HI_ZERO);
    assign wr_take = i_bus_req && i_bus_wr;
    assign rd_take = i_bus_req && !i_bus_wr;
    assign tgt = strobe_hit ? tgt_strobe :
                 ctrl_hit ? tgt_ctrl :
                 relay_hit ? tgt_relay : tgt_rsvd;

    // ----------------------------------------
    // control register
    // ----------------------------------------
    logic [2:0] ctrl_q;
    logic [2:0] ctrl_d;

    // control bits shown in place, every other bit reads zero
    function automatic sms_word_t ctrl_word(input logic [2:0] c);
        return `SMS_DW'(c) << `SMS_CTRL_LO;
    endfunction

    // only latch, polarity and power fail gate are held here
    assign ctrl_d = (wr_take && ctrl_hit) ? i_bus_wdata[`SMS_CTRL_HI:`SMS_CTRL_LO] : ctrl_q;

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            ctrl_q <= `SMS_CTRL_RST;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // unused on non-latching variants
    assign o_latch_multi_coil = ctrl_q[`SMS_CTRL_LATCH] && i_latching_variant;

    // ----------------------------------------
    // trace advance and power fail
    // ----------------------------------------
    logic trace_q;
    logic relay_reset_q;
    wire relay_reset_d;

    // gate bit low lets the power fail line clear the relays
    assign relay_reset_d = !i_bus_power_fail_line_n && !ctrl_q[`SMS_CTRL_PF];

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            trace_q <= 1'b0;
            relay_reset_q <= 1'b0;
        end else begin
            trace_q <= wr_take && strobe_hit;
            relay_reset_q <= relay_reset_d;
        end
    end

    assign o_trace_advance = trace_q;
    assign o_relay_reset = relay_reset_q;

    // ----------------------------------------
    // relay data store
    // ----------------------------------------
    sms_word_t relay_rdata;
    wire relay_we;
    wire relay_clear;

    assign relay_we = wr_take && relay_hit;
    // a pending power fail wins over a host write to the same word
    assign relay_clear = i_srst || relay_reset_q;

    sms_relay_store u_store (
        .i_core_clk(i_core_clk),
        .i_clear(relay_clear),
        .i_we(relay_we),
        .i_addr(mod_off[`SMS_RELAY_AW:1]),
        .i_wdata(i_bus_wdata),
        .o_rdata(relay_rdata)
    );

    // ----------------------------------------
    // read pipeline: take, then answer
    // ----------------------------------------
    logic pend_q;
    logic pend_rd_q;
    sms_tgt_t tgt_q;
    sms_word_t stat_q;
    logic ack_q;
    sms_word_t rdata_q;
    sms_word_t rdata_d;
    wire [`SMS_DW-1:0] pol_mask;

    assign pol_mask = {`SMS_DW{ctrl_q[`SMS_CTRL_POL]}};

    // status and control never pass through the polarity mask
    assign rdata_d = !pend_rd_q ? '0 :
        (tgt_q == tgt_strobe) ? stat_q :
        (tgt_q == tgt_ctrl) ? ctrl_word(ctrl_q) :
        (tgt_q == tgt_relay) ? (relay_rdata ^ pol_mask) :
        `SMS_ONES;

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            pend_q <= 1'b0;
            pend_rd_q <= 1'b0;
            tgt_q <= tgt_rsvd;
            stat_q <= '0;
        end else begin
            pend_q <= i_bus_req;
            pend_rd_q <= rd_take;
            tgt_q <= tgt;
            stat_q <= {`SMS_STAT_PAD, i_double_wide, i_module_busy};
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            ack_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            ack_q <= pend_q;
            rdata_q <= rdata_d;
        end
    end

    assign o_bus_ack = ack_q;
    assign o_bus_rdata = rdata_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_srst);

    chk_strobe_event: assert property (
        wr_take && strobe_hit |=> o_trace_advance
    ) else $error("strobe write gave no trace advance");

    chk_trace_cause: assert property (
        o_trace_advance |-> $past(wr_take && strobe_hit)
    ) else $error("trace advance without strobe write");

    chk_status_pad: assert property (
        rd_take && strobe_hit |-> ##2 o_bus_ack
            && (o_bus_rdata[`SMS_DW-1:`SMS_STAT_PAD_LSB] == `SMS_STAT_PAD)
    ) else $error("status upper bits not ones");

    chk_status_width: assert property (
        rd_take && strobe_hit |-> ##2 o_bus_rdata[`SMS_STAT_WIDE] == $past(i_double_wide, 2)
    ) else $error("status width bit wrong");

    chk_status_busy: assert property (
        rd_take && strobe_hit |-> ##2 o_bus_rdata[`SMS_STAT_WIDE-1:0] == $past(i_module_busy, 2)
    ) else $error("status busy bits wrong");

    chk_rsvd_ones: assert property (
        rd_take && (tgt == tgt_rsvd) |-> ##2 o_bus_rdata == `SMS_ONES
    ) else $error("reserved read not all ones");

    chk_unused_module: assert property (
        rd_take && i_bus_ext && (mod_idx != `SMS_IMPL_MOD) |-> ##2 o_bus_rdata == `SMS_ONES
    ) else $error("unused module window answered");

    chk_ctrl_readback: assert property (
        rd_take && ctrl_hit |-> ##2 o_bus_rdata == ctrl_word($past(ctrl_q))
    ) else $error("control read back altered");

    chk_ctrl_write: assert property (
        wr_take && ctrl_hit |=> ctrl_q == $past(i_bus_wdata[`SMS_CTRL_HI:`SMS_CTRL_LO])
    ) else $error("control write at 0x200 not stored");

    chk_latch_gate: assert property (
        !i_latching_variant |-> !o_latch_multi_coil
    ) else $error("latch mode on non-latching variant");

    chk_pf_gate: assert property (
        !i_bus_power_fail_line_n && !ctrl_q[`SMS_CTRL_PF] |=> o_relay_reset
    ) else $error("power fail did not reset relays");

    chk_pf_block: assert property (
        ctrl_q[`SMS_CTRL_PF] && $stable(ctrl_q) |=> !o_relay_reset
    ) else $error("power fail reset not suppressed");

    chk_rst_ctrl: assert property (
        $fell(i_srst) |-> ctrl_q == `SMS_CTRL_RST
    ) else $error("control not zero after reset");
endmodule

// [tb/sms_host.sv]
// host bus model: one-cycle request per completed host cycle
// assumes the bench calls its tasks at a falling edge of the clock
`timescale 1ns/10ps
`include "sms_consts.svh"
module sms_host
    import sms_pkg::*;
(
    // clock
    input wire logic i_core_clk,
    // request side
    output logic o_req,
    output logic o_wr,
    output logic o_ext,
    output logic [`SMS_EXT_AW-1:0] o_addr,
    output sms_word_t o_wdata
);
    initial begin
        o_req = 1'b0;
        o_wr = 1'b0;
        o_ext = 1'b0;
        o_addr = 13'h0000;
        o_wdata = 16'h0000;
    end
    // request stays up so calls chain back to back
    task automatic xfer(input logic wr, input logic ext, input logic [12:0] a, input sms_word_t d);
        o_req = 1'b1;
        o_wr = wr;
        o_ext = ext;
        o_addr = a;
        o_wdata = d;
        @(negedge i_core_clk);
    endtask
    task automatic idle();
        o_req = 1'b0;
        // released address and data lines carry junk so a stale value never looks valid
        o_addr = ~o_addr;
        o_wdata = ~o_wdata;
        @(negedge i_core_clk);
    endtask
endmodule

// [tb/switch_module_status_control_regs_bench.sv]
// self-checking bench of the carrier register bank
// assumes sms_host drives the bus; answers checked in order of request
`timescale 1ns/10ps
`include "sms_consts.svh"
module switch_module_status_control_regs_bench
    import sms_pkg::*;
;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic req, wr, ext, ack, wide, latv, pf_n, trace, latch, rrst;
    logic [12:0] addr;
    logic [5:0] busy;
    sms_word_t wdata, rdata, d0, d1;
    sms_word_t q[$];
    int err_total = 0;
    int checked = 0;
    int ntr = 0;
    logic [12:0] rsv[6] = '{13'h0000, 13'h003c, 13'h0202, 13'h0600, 13'h1a00, 13'h0400};
    always #50 clk = ~clk;
    sms_host host (.i_core_clk(clk), .o_req(req), .o_wr(wr), .o_ext(ext),
        .o_addr(addr), .o_wdata(wdata));
    sms_regs uut (.i_core_clk(clk), .i_srst(srst), .i_bus_req(req), .i_bus_wr(wr),
        .i_bus_ext(ext), .i_bus_addr(addr), .i_bus_wdata(wdata), .o_bus_ack(ack),
        .o_bus_rdata(rdata), .i_double_wide(wide), .i_module_busy(busy),
        .i_latching_variant(latv), .i_bus_power_fail_line_n(pf_n),
        .o_trace_advance(trace), .o_latch_multi_coil(latch), .o_relay_reset(rrst));
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        if (err_total == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic rd(input logic e, input logic [12:0] a, input sms_word_t x);
        q.push_back(x);
        host.xfer(1'b0, e, a, 16'($urandom));
    endtask
    task automatic wrt(input logic e, input logic [12:0] a, input sms_word_t d);
        q.push_back(16'h0000);
        host.xfer(1'b1, e, a, d);
    endtask
    // ----------------------------------------
    // answer monitor
    // ----------------------------------------
    always @(negedge clk) begin
        if (trace === 1'b1)
            ntr++;
        if (ack === 1'b1) begin
            if (q.size() == 0)
                chk("spare ack", 16'h1, 16'h0);
            else
                chk("rdata", rdata, q.pop_front());
        end
    end
    initial begin
        #2000000;
        err_total++;
        tally_and_finish();
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        {wide, latv, pf_n, busy} = 9'h044;
        void'($urandom(38138));
        repeat (2) @(negedge clk);
        srst = 1'b0;
        chk("latch", latch, 16'h0);
        chk("relay reset", rrst, 16'h0);
        rd(1'b1, 13'h0200, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            wide = 1'($urandom);
            busy = 6'($urandom);
            rd(1'b0, 13'h003e, {9'h1ff, wide, busy});
        end
        foreach (rsv[i]) begin
            wrt(rsv[i] > 13'h3f, rsv[i], 16'($urandom));
            rd(rsv[i] > 13'h3f, rsv[i], 16'hffff);
        end
        rd(1'b1, 13'h0200, 16'h0000);
        for (int i = 0; i < 3; i++)
            wrt(1'b0, 13'h003e, 16'($urandom));
        host.idle();
        repeat (3) @(negedge clk);
        chk("trace count", 16'(ntr), 16'h3);
        d0 = 16'($urandom);
        d1 = 16'($urandom);
        wrt(1'b1, 13'h0000, d0);
        wrt(1'b1, 13'h001e, d1);
        rd(1'b1, 13'h0000, d0);
        rd(1'b1, 13'h001e, d1);
        wrt(1'b1, 13'h0200, 16'hffff);
        rd(1'b1, 13'h0200, 16'h0700);
        rd(1'b0, 13'h003e, {9'h1ff, wide, busy});
        rd(1'b1, 13'h001e, ~d1);
        host.idle();
        chk("latch", latch, 16'h0);
        latv = 1'b1;
        @(negedge clk);
        chk("latch", latch, 16'h1);
        pf_n = 1'b0;
        repeat (3) @(negedge clk);
        chk("relay reset", rrst, 16'h0);
        rd(1'b1, 13'h0000, ~d0);
        wrt(1'b1, 13'h0200, 16'h0000);
        host.idle();
        @(negedge clk);
        chk("relay reset", rrst, 16'h1);
        chk("latch", latch, 16'h0);
        pf_n = 1'b1;
        repeat (2) @(negedge clk);
        chk("relay reset", rrst, 16'h0);
        rd(1'b1, 13'h0000, 16'h0000);
        host.idle();
        repeat (4) @(negedge clk);
        chk("queue left", 16'(q.size()), 16'h0);
        tally_and_finish();
    end
endmodule
